// *** include/fan_regs_pkg.sv ***
// Register map, field positions, reset values and timing tables of the fan
// monitor register bank. Shared by the design and the bench.
package fan_regs_pkg;

    // Clock rate (Hz) and time units
    localparam int unsigned CLK_HZ_NOM = 32'h0262_5a00; // 40 MHz
    localparam int unsigned MS_PER_S = 32'h0000_03e8;
    localparam int unsigned S_PER_MIN = 32'h0000_003c;

    // Register indices; byte address on the bus is four times the index
    localparam logic [7:0] IDX_CFG_ONE = 8'h00;
    localparam logic [7:0] IDX_CFG_TWO = 8'h01;
    localparam logic [7:0] IDX_STAT_ONE = 8'h02;
    localparam logic [7:0] IDX_STAT_TWO = 8'h03;
    localparam logic [7:0] IDX_EXT_FRAC = 8'h06;
    localparam logic [7:0] IDX_FAN_CHAR = 8'h20;
    localparam logic [7:0] IDX_MASK_ONE = 8'h30;
    localparam logic [7:0] IDX_MASK_TWO = 8'h31;

    // Values after reset
    localparam logic [7:0] CFG_ONE_RST = 8'h90;
    localparam logic [7:0] CFG_TWO_RST = 8'h7f;
    localparam logic [7:0] STAT_RST = 8'h00;
    localparam logic [7:0] FAN_CHAR_RST = 8'h5d;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [1:0] PIN_IDLE = 2'h3;

    // Field positions
    localparam int unsigned CFG1_MONITOR = 0;
    localparam int unsigned CFG1_INT_EN = 1;
    localparam int unsigned CFG2_SOFT_RST = 7;
    localparam int unsigned S1_ALARM = 0;
    localparam int unsigned S1_FAN_FAULT = 1;
    localparam int unsigned S1_REM_CRIT = 4;
    localparam int unsigned S1_DIODE_ERR = 5;
    localparam int unsigned S2_LOC_CRIT = 6;
    localparam int unsigned S2_THERM = 7;
    localparam int unsigned FC_SPIN_LSB = 0;
    localparam int unsigned FC_FREQ_LSB = 3;
    localparam int unsigned FC_RANGE_LSB = 6;

    // Spin-up drive times in ms, PWM frequencies in mHz, per 3-bit code
    localparam int unsigned SPINUP_MS [8] = '{32'h0000_00c8, 32'h0000_0190, 32'h0000_0258,
        32'h0000_0320, 32'h0000_03e8, 32'h0000_07d0, 32'h0000_0fa0, 32'h0000_1f40};
    localparam int unsigned PWM_FREQ_MHZ [8] = '{32'h0000_2db4, 32'h0000_3cf0,
        32'h0000_5b68, 32'h0000_7a12, 32'h0000_927c, 32'h0000_b734, 32'h0000_f424,
        32'h0001_6d3c};
    // Stall speed with range N = 1, in RPM
    localparam int unsigned FAIL_RPM_BASE = 32'h0000_0a57;

    typedef struct packed {
        logic soft_rst;
        logic rsvd6;
        logic rem_irq_en;
        logic loc_irq_en;
        logic rsvd3;
        logic tach_en;
        logic rsvd1;
        logic pwm_en;
    } cfg_two_s;

    typedef struct packed {
        logic loc_low;
        logic loc_high;
        logic loc_crit;
        logic rem_low;
        logic rem_high;
        logic rem_crit;
    } temp_events_s;

endpackage : fan_regs_pkg

// *** hdl/fan_monitor_status_config_regs.sv ***
// Configuration, status and fan-characteristic register bank of a temperature
// monitor and PWM fan controller, with PWM, tach and overtemperature pins.
// Assumes an Avalon-MM master on clk_i, limit comparisons and fractional
// temperature bits delivered by the conversion logic, and a monitoring tick.
// Functional notes
// - PWM output drives only while enabled
// - Tach input measured only while enabled
// - Local channel interrupts gated by enable bit
// - Remote interrupt gate; cleared if diode fault
// - Soft reset bit resets device, self-clears
// - Alarm-speed flag not re-set after read
// - Fan fault flag re-sets each monitoring cycle
// - Remote high/low flags re-set while condition
// - Remote critical flag stays clear after read
// - Diode fault checked at power-up, not read-cleared
// - Local high/low flags re-set while condition
// - Local critical flag stays clear after read
// - Overtemperature pin low sets flag, full speed
// - Fraction register: remote 2:0, local 7:6
// - Spin-up time selected by fan field 2:0
// - PWM frequency selected by field 5:3
// - Speed range N scales stall threshold
// - Monitoring cycles run only when monitor bit set
`timescale 1ns/100ps
module fan_monitor_status_config_regs #(
    parameter int unsigned CLK_HZ = fan_regs_pkg::CLK_HZ_NOM,
    parameter int unsigned TACH_PULSES_PER_REV = 2
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [9:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic mon_tick_i,
    input wire fan_regs_pkg::temp_events_s temp_ev_i,
    input wire logic diode_fault_i,
    input wire logic [2:0] rem_frac_i,
    input wire logic [1:0] loc_frac_i,
    input wire logic [7:0] duty_i,
    input wire logic tach_pin_i,
    input wire logic therm_n_pin_i,
    output logic pwm_o,
    output logic tach_pulse_o,
    output logic fan_full_o,
    output logic irq_o
);
    import fan_regs_pkg::*;

    function automatic logic [31:0] spin_cycles(input logic [2:0] code);
        logic [63:0] c;
        c = (64'(CLK_HZ) * 64'(SPINUP_MS[code]) + 64'(MS_PER_S - 1)) / 64'(MS_PER_S);
        return (c == 64'h0) ? 32'h0000_0001 : c[31:0];
    endfunction : spin_cycles

    function automatic logic [31:0] pwm_period(input logic [2:0] code);
        logic [63:0] c;
        c = (64'(CLK_HZ) * 64'(MS_PER_S)) / 64'(PWM_FREQ_MHZ[code]);
        return (c == 64'h0) ? 32'h0000_0001 : c[31:0];
    endfunction : pwm_period

    function automatic logic [31:0] stall_cycles(input logic [1:0] range);
        logic [63:0] c;
        c = (64'(CLK_HZ) * 64'(S_PER_MIN)) / (64'(FAIL_RPM_BASE) * 64'(TACH_PULSES_PER_REV));
        c = c << range;
        return (c == 64'h0) ? 32'h0000_0001 : c[31:0];
    endfunction : stall_cycles

    logic dev_rst;
    logic soft_rst_r;
    logic ack_r;
    logic req;
    logic wr_acc;
    logic rd_acc;
    logic [7:0] idx;
    logic [7:0] wdata;
    logic wr_lane;
    logic [7:0] rd_val;
    logic [31:0] readdata_r;
    logic [7:0] cfg1_r;
    cfg_two_s cfg2_r;
    logic [7:0] fan_char_r;
    logic [7:0] mask1_r;
    logic [7:0] mask2_r;
    logic [7:0] s1_r;
    logic [7:0] s2_r;
    logic [7:0] s1_val;
    logic [7:0] s2_val;
    logic [7:0] set1;
    logic [7:0] set2;
    logic [7:0] clr1;
    logic [7:0] clr2;
    logic [2:0] blk_r;
    logic [2:0] crit_cond;
    logic [2:0] rd_clr;
    logic [7:0] ext_frac_r;
    logic diode_err_r;
    logic diode_pend_r;
    logic mon_cycle;
    logic [1:0] sync1_r;
    logic [1:0] sync2_r;
    logic [1:0] sync3_r;
    logic [1:0] pin_lvl_r;
    logic tach_d_r;
    logic tach_rise;
    logic therm_act;
    logic therm_d_r;
    logic [31:0] tach_cnt_r;
    logic stall_r;
    logic pwm_en_d_r;
    logic [31:0] spin_cnt_r;
    logic fan_full_r;
    logic alarm_cond;
    logic [31:0] pwm_cnt_r;
    logic [31:0] pwm_per;
    logic [31:0] pwm_thr;
    logic pwm_r;
    logic tach_pulse_r;
    logic irq_r;
    logic [7:0] gate1;
    logic [7:0] gate2;

    // Bus slave: one wait cycle, then the request is taken
    assign req = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = req & ~ack_r;
    assign wr_acc = avs_write_i & ack_r;
    assign rd_acc = avs_read_i & ack_r;
    assign idx = avs_address_i[9:2];
    assign wdata = avs_writedata_i[7:0];
    assign wr_lane = wr_acc & avs_byteenable_i[0];
    assign avs_readdata_o = readdata_r;
    assign dev_rst = srst_i | soft_rst_r;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    // Soft reset pulse lasts one cycle; the bit itself is never stored
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            soft_rst_r <= 1'b0;
        end else begin
            soft_rst_r <= wr_lane & (idx == IDX_CFG_TWO) & wdata[CFG2_SOFT_RST];
        end
    end

    always_comb begin
        case (idx)
            IDX_CFG_ONE: rd_val = cfg1_r;
            IDX_CFG_TWO: rd_val = {1'b0, cfg2_r[6:0]};
            IDX_STAT_ONE: rd_val = s1_val;
            IDX_STAT_TWO: rd_val = s2_val;
            IDX_EXT_FRAC: rd_val = ext_frac_r;
            IDX_FAN_CHAR: rd_val = fan_char_r;
            IDX_MASK_ONE: rd_val = mask1_r;
            IDX_MASK_TWO: rd_val = mask2_r;
            default: rd_val = 8'h00;
        endcase
    end

    // Read data is caught in the wait cycle and doubles as the clear snapshot
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            readdata_r <= 32'h0000_0000;
        end else if (avs_read_i & ~ack_r) begin
            readdata_r <= {24'h00_0000, rd_val};
        end
    end

    // Diode test: once, after power-on reset only
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            diode_pend_r <= 1'b1;
            diode_err_r <= 1'b0;
        end else if (diode_pend_r) begin
            diode_pend_r <= 1'b0;
            diode_err_r <= diode_fault_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (dev_rst) begin
            cfg1_r <= CFG_ONE_RST;
            fan_char_r <= FAN_CHAR_RST;
            mask1_r <= MASK_RST;
            mask2_r <= MASK_RST;
        end else if (wr_lane) begin
            if (idx == IDX_CFG_ONE) cfg1_r <= wdata;
            if (idx == IDX_FAN_CHAR) fan_char_r <= wdata;
            if (idx == IDX_MASK_ONE) mask1_r <= wdata;
            if (idx == IDX_MASK_TWO) mask2_r <= wdata;
        end
    end

    // Remote interrupt gate comes up cleared when the diode is faulty
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cfg2_r <= cfg_two_s'(CFG_TWO_RST);
        end else if (soft_rst_r) begin
            cfg2_r <= cfg_two_s'(CFG_TWO_RST);
            cfg2_r.rem_irq_en <= ~diode_err_r;
        end else if (diode_pend_r) begin
            if (diode_fault_i) cfg2_r.rem_irq_en <= 1'b0;
        end else if (wr_lane & (idx == IDX_CFG_TWO)) begin
            cfg2_r <= cfg_two_s'({1'b0, wdata[6:0]});
        end
    end

    // Pins cross into clk_i through three flops; a change counts once two agree
    assign therm_act = ~pin_lvl_r[1];
    generate
        for (genvar g = 0; g < 2; g++) begin : g_pin
            always_ff @(posedge clk_i) begin
                if (srst_i) begin
                    sync1_r[g] <= PIN_IDLE[g];
                    sync2_r[g] <= PIN_IDLE[g];
                    sync3_r[g] <= PIN_IDLE[g];
                    pin_lvl_r[g] <= PIN_IDLE[g];
                end else begin
                    sync1_r[g] <= g ? therm_n_pin_i : tach_pin_i;
                    sync2_r[g] <= sync1_r[g];
                    sync3_r[g] <= sync2_r[g];
                    if (sync2_r[g] == sync3_r[g]) pin_lvl_r[g] <= sync3_r[g];
                end
            end
        end
    endgenerate

    assign mon_cycle = mon_tick_i & cfg1_r[CFG1_MONITOR];
    assign tach_rise = pin_lvl_r[0] & ~tach_d_r & cfg2_r.tach_en;

    // Tach period counter; a stall is a gap longer than the range threshold
    always_ff @(posedge clk_i) begin
        if (dev_rst) begin
            tach_d_r <= PIN_IDLE[0];
            tach_cnt_r <= 32'h0000_0000;
            stall_r <= 1'b0;
            tach_pulse_r <= 1'b0;
        end else begin
            tach_d_r <= pin_lvl_r[0];
            tach_pulse_r <= tach_rise;
            if (!(cfg2_r.tach_en & cfg1_r[CFG1_MONITOR]) || tach_rise) begin
                tach_cnt_r <= 32'h0000_0000;
                stall_r <= 1'b0;
            end else if (tach_cnt_r >= stall_cycles(fan_char_r[FC_RANGE_LSB +: 2])) begin
                stall_r <= 1'b1;
            end else begin
                tach_cnt_r <= tach_cnt_r + 32'h0000_0001;
            end
        end
    end

    // Spin-up holds full drive for the selected time after the output is enabled
    always_ff @(posedge clk_i) begin
        if (dev_rst) begin
            pwm_en_d_r <= 1'b0;
            spin_cnt_r <= 32'h0000_0000;
            therm_d_r <= 1'b0;
            fan_full_r <= 1'b0;
        end else begin
            pwm_en_d_r <= cfg2_r.pwm_en;
            therm_d_r <= therm_act;
            if (cfg2_r.pwm_en & ~pwm_en_d_r) begin
                spin_cnt_r <= spin_cycles(fan_char_r[FC_SPIN_LSB +: 3]);
            end else if (spin_cnt_r != 32'h0000_0000) begin
                spin_cnt_r <= spin_cnt_r - 32'h0000_0001;
            end
            fan_full_r <= therm_act | (spin_cnt_r != 32'h0000_0000);
        end
    end

    assign pwm_per = pwm_period(fan_char_r[FC_FREQ_LSB +: 3]);
    assign pwm_thr = 32'((64'(pwm_per) * 64'(duty_i)) >> 8);

    always_ff @(posedge clk_i) begin
        if (dev_rst) begin
            pwm_cnt_r <= 32'h0000_0000;
            pwm_r <= 1'b0;
        end else begin
            // A frequency change takes effect at once; the period may be cut short
            if (pwm_cnt_r >= pwm_per - 32'h0000_0001) begin
                pwm_cnt_r <= 32'h0000_0000;
            end else begin
                pwm_cnt_r <= pwm_cnt_r + 32'h0000_0001;
            end
            pwm_r <= cfg2_r.pwm_en & (fan_full_r | (duty_i == 8'hff) | (pwm_cnt_r < pwm_thr));
        end
    end

    assign alarm_cond = cfg2_r.pwm_en & fan_full_r;
    assign crit_cond = {temp_ev_i.loc_crit, temp_ev_i.rem_crit, alarm_cond};
    assign rd_clr = {rd_acc & (idx == IDX_STAT_TWO) & readdata_r[S2_LOC_CRIT],
                     rd_acc & (idx == IDX_STAT_ONE) & readdata_r[S1_REM_CRIT],
                     rd_acc & (idx == IDX_STAT_ONE) & readdata_r[S1_ALARM]};

    // A flag read away stays blocked until its condition goes away
    always_ff @(posedge clk_i) begin
        if (dev_rst) begin
            blk_r <= 3'h0;
        end else begin
            blk_r <= crit_cond & (blk_r | rd_clr);
        end
    end

    always_comb begin
        set1 = 8'h00;
        set2 = 8'h00;
        if (mon_cycle) begin
            set1[S1_ALARM] = alarm_cond & ~blk_r[0];
            set1[S1_FAN_FAULT] = stall_r;
            set1[2] = temp_ev_i.rem_high;
            set1[3] = temp_ev_i.rem_low;
            set1[S1_REM_CRIT] = temp_ev_i.rem_crit & ~blk_r[1];
            set1[6] = temp_ev_i.loc_high;
            set1[7] = temp_ev_i.loc_low;
            set2[S2_LOC_CRIT] = temp_ev_i.loc_crit & ~blk_r[2];
        end
        set2[S2_THERM] = therm_act & ~therm_d_r;
    end

    // Only bits that the finished read returned are cleared; write one also clears
    assign clr1 = ((rd_acc & (idx == IDX_STAT_ONE)) ? readdata_r[7:0] : 8'h00)
                | ((wr_lane & (idx == IDX_STAT_ONE)) ? wdata : 8'h00);
    assign clr2 = ((rd_acc & (idx == IDX_STAT_TWO)) ? readdata_r[7:0] : 8'h00)
                | ((wr_lane & (idx == IDX_STAT_TWO)) ? wdata : 8'h00);

    always_ff @(posedge clk_i) begin
        if (dev_rst) begin
            s1_r <= STAT_RST;
            s2_r <= STAT_RST;
        end else begin
            s1_r <= (s1_r & ~clr1) | set1;
            s2_r <= (s2_r & ~clr2) | set2;
        end
    end

    assign s1_val = s1_r | (8'(diode_err_r) << S1_DIODE_ERR);
    assign s2_val = s2_r & 8'hc0;

    always_ff @(posedge clk_i) begin
        if (dev_rst) begin
            ext_frac_r <= STAT_RST;
        end else if (mon_cycle) begin
            ext_frac_r <= {loc_frac_i, 3'h0, rem_frac_i};
        end
    end

    // Fan bits are never gated by channel; remote bits 2..5, local bits 6..7
    assign gate1 = {{2{cfg2_r.loc_irq_en}}, {4{cfg2_r.rem_irq_en}}, 2'h3};
    assign gate2 = {1'b1, cfg2_r.loc_irq_en, 6'h00};

    always_ff @(posedge clk_i) begin
        if (dev_rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= cfg1_r[CFG1_INT_EN]
                   & (|(s1_val & mask1_r & gate1) | |(s2_val & mask2_r & gate2));
        end
    end

    assign pwm_o = pwm_r;
    assign tach_pulse_o = tach_pulse_r;
    assign fan_full_o = fan_full_r;
    assign irq_o = irq_r;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    pwm_gate_a: assert property (!cfg2_r.pwm_en |=> !pwm_o)
        else $error("PWM output active while disabled");
    tach_gate_a: assert property (tach_pulse_o |-> $past(cfg2_r.tach_en))
        else $error("Tach pulse while tach disabled");
    irq_gate_a: assert property ((!cfg2_r.loc_irq_en && !cfg2_r.rem_irq_en
        && (s1_val[1:0] & mask1_r[1:0]) == 2'h0 && !(s2_val[7] && mask2_r[7])
        && !soft_rst_r) |=> !irq_o)
        else $error("Interrupt raised by a gated channel");
    soft_clear_a: assert property (soft_rst_r |=> (s1_r == STAT_RST
        && fan_char_r == FAN_CHAR_RST && !soft_rst_r))
        else $error("Soft reset did not restore registers");
    // A tick in the very edge of the read may still leave the flag up; it must not rise again
    alarm_block_a: assert property ((blk_r[0] && alarm_cond && !soft_rst_r)
        |=> !$rose(s1_r[S1_ALARM]))
        else $error("Alarm flag reasserted after read");
    fault_repeat_a: assert property ((mon_cycle && stall_r && !soft_rst_r)
        |=> s1_r[S1_FAN_FAULT])
        else $error("Fan fault not set on monitoring cycle");
    diode_keep_a: assert property (!diode_pend_r |=> $stable(diode_err_r))
        else $error("Diode error changed after power-up");
    therm_flag_a: assert property (($rose(therm_act) && !soft_rst_r)
        |=> ##1 (s2_r[S2_THERM] || $past(clr2[S2_THERM])) && fan_full_o)
        else $error("Overtemperature did not flag and force full speed");
    read_keep_a: assert property ((rd_acc && idx == IDX_STAT_ONE && set1[2]
        && !soft_rst_r) |=> s1_r[2])
        else $error("Event lost during status read");
    monitor_gate_a: assert property ((!cfg1_r[CFG1_MONITOR] && !s1_r[7] && !soft_rst_r)
        |=> !s1_r[7])
        else $error("Status flag set with monitoring off");
    spin_load_a: assert property (($rose(cfg2_r.pwm_en) && !soft_rst_r)
        |=> spin_cnt_r == spin_cycles(fan_char_r[FC_SPIN_LSB +: 3]))
        else $error("Spin-up time not loaded");

    read_clear_c: cover property (rd_acc && idx == IDX_STAT_ONE && readdata_r[2]);
    soft_rst_c: cover property (soft_rst_r);
    therm_c: cover property ($rose(therm_act));
    stall_c: cover property ($rose(stall_r));

endmodule : fan_monitor_status_config_regs

// *** verification/fan_model.sv ***
// Behavioural cooling fan whose tach line toggles while the rotor turns.
// Assumes the bench commands a stall through run_i.
`timescale 1ns/100ps
module fan_model #(
    parameter int unsigned HALF = 60
) (
    input wire logic clk_i,
    input wire logic run_i,
    output logic tach_o
);
    int cnt = 0;
    logic lvl = 1'b1;
    assign tach_o = lvl;
    // A stalled rotor parks the tach line wherever it stopped
    always @(posedge clk_i) begin
        if (run_i) begin
            cnt <= (cnt + 1 == HALF) ? 0 : cnt + 1;
            if (cnt + 1 == HALF) begin
                lvl <= ~lvl;
            end
        end
    end
endmodule : fan_model

// *** verification/tb.sv ***
// Self-checking bench of the fan monitor register bank, with a fan model.
// Assumes one 40 MHz clock; CLK_HZ is shrunk so spin-up and stall are short.
`timescale 1ns/100ps
module tb;
    import fan_regs_pkg::*;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [9:0] addr = '0;
    logic rd_en = 1'b0;
    logic wr_en = 1'b0;
    logic [31:0] wdata = '0;
    logic [31:0] rdata;
    logic wait_o, tach, pwm, tpulse, full, irq;
    logic tick = 1'b0;
    temp_events_s ev = '0;
    logic diode = 1'b0;
    logic [2:0] rfrac = '0;
    logic [1:0] lfrac = '0;
    logic therm_n = 1'b1;
    logic run = 1'b1;
    logic [3:0] be = 4'h1;
    logic [7:0] d, v;
    int miscompares = 0;
    int checked = 0;
    int npwm = 0;
    int ntach = 0;
    int k;

    always #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        npwm <= npwm + (pwm === 1'b1);
        ntach <= ntach + (tpulse === 1'b1);
    end

    fan_monitor_status_config_regs #(.CLK_HZ(40000)) DUT (
        .clk_i(clk_i), .srst_i(srst_i), .avs_address_i(addr), .avs_read_i(rd_en),
        .avs_write_i(wr_en), .avs_writedata_i(wdata), .avs_byteenable_i(be),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o), .mon_tick_i(tick),
        .temp_ev_i(ev), .diode_fault_i(diode), .rem_frac_i(rfrac), .loc_frac_i(lfrac),
        .duty_i(8'h80), .tach_pin_i(tach), .therm_n_pin_i(therm_n), .pwm_o(pwm),
        .tach_pulse_o(tpulse), .fan_full_o(full), .irq_o(irq));
    fan_model FAN (.clk_i(clk_i), .run_i(run), .tach_o(tach));

    function automatic logic [7:0] frac_exp(input logic [2:0] r, input logic [1:0] l);
        return {l, 3'h0, r};
    endfunction : frac_exp
    // Critical flag is expected only on its first report
    function automatic logic [7:0] st1_exp(input temp_events_s e, input logic crit);
        return {e.loc_low, e.loc_high, 1'h0, e.rem_crit & crit, e.rem_low, e.rem_high, 2'h0};
    endfunction : st1_exp

    task automatic finish_test();
        if (miscompares == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Holds the request until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] val);
        int n;
        n = 0;
        addr <= {idx, 2'h0};
        wdata <= {24'h00_0000, val};
        rd_en <= ~w;
        wr_en <= w;
        do begin
            @(posedge clk_i);
            n++;
        end while (wait_o !== 1'b0 && n < 100);
        if (n >= 100) chk({7'h00, wait_o}, 8'h00);
        d = rdata[7:0];
        rd_en <= 1'b0;
        wr_en <= 1'b0;
        @(posedge clk_i);
    endtask : bus

    task automatic rdc(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] e);
        bus(1'b0, idx, 8'h00);
        chk(d & m, e);
    endtask : rdc

    task automatic mtick();
        tick <= 1'b1;
        @(posedge clk_i);
        tick <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask : mtick

    task automatic settle(input int cyc);
        repeat (cyc) @(posedge clk_i);
    endtask : settle

    task automatic count(ref int c, output int n);
        int s;
        s = c;
        settle(1500);
        n = c - s;
    endtask : count

    task automatic reset(input logic df);
        diode <= df;
        srst_i <= 1'b1;
        settle(20);
        srst_i <= 1'b0;
        @(posedge clk_i);
    endtask : reset

    initial begin
        settle(60000);
        miscompares++;
        finish_test();
    end

    initial begin
        void'($urandom(32'h0000_1167));
        reset(1'b0);
        rdc(IDX_CFG_ONE, 8'hff, CFG_ONE_RST);
        rdc(IDX_CFG_TWO, 8'hff, 8'h7f);
        rdc(IDX_STAT_ONE, 8'hff, 8'h00);
        rdc(IDX_STAT_TWO, 8'hff, 8'h00);
        rdc(IDX_EXT_FRAC, 8'hff, 8'h00);
        rdc(IDX_FAN_CHAR, 8'hff, 8'h5d);
        bus(1'b1, 8'h10, 8'h5a);
        rdc(8'h10, 8'hff, 8'h00);
        // A write without the low byte lane must not land
        be <= 4'h2;
        bus(1'b1, IDX_MASK_TWO, 8'h5a);
        be <= 4'h1;
        rdc(IDX_MASK_TWO, 8'hff, MASK_RST);
        repeat (4) begin
            v = 8'($urandom);
            bus(1'b1, IDX_FAN_CHAR, v);
            rdc(IDX_FAN_CHAR, 8'hff, v);
        end
        bus(1'b1, IDX_CFG_TWO, 8'hff);
        rdc(IDX_CFG_TWO, 8'hff, 8'h7f);
        rdc(IDX_FAN_CHAR, 8'hff, 8'h5d);
        ev <= temp_events_s'(6'($urandom) | 6'h09);
        rfrac <= 3'($urandom);
        lfrac <= 2'($urandom);
        mtick();
        rdc(IDX_STAT_ONE, 8'hff, 8'h00);
        bus(1'b1, IDX_CFG_ONE, 8'h91);
        mtick();
        rdc(IDX_EXT_FRAC, 8'hff, frac_exp(rfrac, lfrac));
        rdc(IDX_STAT_ONE, 8'hdc, st1_exp(ev, 1'b1));
        rdc(IDX_STAT_TWO, 8'hff, {1'h0, ev.loc_crit, 6'h00});
        rdc(IDX_STAT_ONE, 8'hdc, 8'h00);
        mtick();
        rdc(IDX_STAT_ONE, 8'hdc, st1_exp(ev, 1'b0));
        rdc(IDX_STAT_TWO, 8'hff, 8'h00);
        ev <= temp_events_s'(6'h10);
        bus(1'b1, IDX_CFG_ONE, 8'h93);
        mtick();
        chk({7'h00, irq}, 8'h00);
        bus(1'b1, IDX_MASK_ONE, 8'hc0);
        settle(2);
        chk({7'h00, irq}, 8'h01);
        bus(1'b1, IDX_CFG_TWO, 8'h6f);
        settle(2);
        chk({7'h00, irq}, 8'h00);
        bus(1'b1, IDX_CFG_TWO, 8'h7f);
        ev <= '0;
        bus(1'b1, IDX_STAT_ONE, 8'hc0);
        settle(2);
        chk({7'h00, irq}, 8'h00);
        run <= 1'b0;
        settle(1200);
        mtick();
        rdc(IDX_STAT_ONE, 8'h02, 8'h02);
        mtick();
        rdc(IDX_STAT_ONE, 8'h02, 8'h02);
        run <= 1'b1;
        settle(300);
        mtick();
        bus(1'b0, IDX_STAT_ONE, 8'h00);
        mtick();
        rdc(IDX_STAT_ONE, 8'h02, 8'h00);
        count(ntach, k);
        chk(8'(k > 0), 8'h01);
        bus(1'b1, IDX_CFG_TWO, 8'h7a);
        count(ntach, k);
        chk(8'(k != 0), 8'h00);
        count(npwm, k);
        chk(8'(k != 0), 8'h00);
        // Shortest spin-up code: 8000 cycles of full drive at the bench's clock rate
        bus(1'b1, IDX_FAN_CHAR, 8'h58);
        bus(1'b1, IDX_CFG_TWO, 8'h7f);
        count(npwm, k);
        chk(8'(k > 0), 8'h01);
        settle(6400);
        chk({7'h00, full}, 8'h01);
        settle(200);
        chk({7'h00, full}, 8'h00);
        therm_n <= 1'b0;
        settle(10);
        chk({7'h00, full}, 8'h01);
        mtick();
        rdc(IDX_STAT_ONE, 8'h01, 8'h01);
        mtick();
        rdc(IDX_STAT_ONE, 8'h01, 8'h00);
        rdc(IDX_STAT_TWO, 8'h80, 8'h80);
        rdc(IDX_STAT_TWO, 8'h80, 8'h00);
        therm_n <= 1'b1;
        reset(1'b1);
        rdc(IDX_CFG_TWO, 8'hff, 8'h5f);
        rdc(IDX_STAT_ONE, 8'h20, 8'h20);
        rdc(IDX_STAT_ONE, 8'h20, 8'h20);
        finish_test();
    end
endmodule : tb
